// ### include/bmpm_pkg.sv
// Constants shared by the bus-mode pin multiplexer and its port core.
// Assumes a 32-bit APB register bus and a 16-pin shared port.
package bmpm_pkg;
   localparam int          GP_W          = 16;
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          CFG_W         = 3;
   localparam int          REG_N         = 5;
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_DIR       = 8'h04;
   localparam logic [7:0]  OFF_DATA      = 8'h08;
   localparam logic [7:0]  OFF_STAT      = 8'h0C;
   localparam logic [7:0]  OFF_MASK      = 8'h10;
   localparam int          SEL_CTRL      = 0;
   localparam int          SEL_DIR       = 1;
   localparam int          SEL_DATA      = 2;
   localparam int          SEL_STAT      = 3;
   localparam int          SEL_MASK      = 4;
   localparam int          CTRL_CFG_LSB  = 0;
   localparam int          CTRL_MODE_BIT = 8;
   localparam int          CTRL_TEST_BIT = 9;
   localparam int          CTRL_SCAN_BIT = 10;
   localparam logic [2:0]  CFG_LBI_ADDR  = 3'h0;
   localparam logic [2:0]  CFG_GPIO      = 3'h4;
   localparam logic [2:0]  CFG_RST       = 3'h7;
   localparam logic        DIR_RST_BIT   = 1'b0;
   localparam logic        DOUT_RST_BIT  = 1'b0;
   localparam logic        MASK_RST_BIT  = 1'b1;
endpackage

// ### include/bmpm_gpio_if.sv
// Signals between the pin multiplexer and its general purpose port core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface bmpm_gpio_if #(parameter int GPW = bmpm_pkg::GP_W);
   logic           en;
   logic [GPW-1:0] mask;
   logic [GPW-1:0] clr;
   logic [GPW-1:0] pins;
   logic [GPW-1:0] lvl;
   logic [GPW-1:0] status;
   logic           irq;
   modport ctrl (output en, mask, clr, pins, input lvl, status, irq);
   modport core (input en, mask, clr, pins, output lvl, status, irq);
endinterface

// ### rtl/bmpm_gpio_core.sv
// Port core: input synchroniser, change detection, sticky status, masked interrupt.
// Assumes pins are sampled on pclk and clears arrive as one-cycle vectors.
`timescale 1ns/1ps
module bmpm_gpio_core #(
   parameter int GPW = bmpm_pkg::GP_W
) (
   input wire logic pclk,
   input wire logic presetn,
   bmpm_gpio_if.core g
);
   import bmpm_pkg::*;

   typedef struct packed {
      logic [GPW-1:0] s1;
      logic [GPW-1:0] s2;
      logic [GPW-1:0] s3;
      logic [GPW-1:0] stat;
   } bmpm_core_st_t;

   bmpm_core_st_t  q;
   bmpm_core_st_t  next_q;
   logic [GPW-1:0] evt;

   always_comb begin
      evt = '0;
      next_q = q;
      next_q.s1 = g.pins;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      if (g.en) begin
         evt = q.s2 ^ q.s3;
      end
      // A change in the clearing cycle still sets its bit.
      next_q.stat = (q.stat & ~g.clr) | evt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign g.lvl    = q.s2;
   assign g.status = q.stat;
   assign g.irq    = |(q.stat & ~g.mask);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sync_delay_a: assert property (1 |-> ##3 (g.lvl == $past(g.pins, 2)))
      else $error("Synchronised level does not follow the pin after two cycles.");
   change_event_a: assert property (
      (g.en && (q.s2 != q.s3)) |=> ((g.status & $past(q.s2 ^ q.s3)) == $past(q.s2 ^ q.s3)))
      else $error("Pin change did not set its status bit.");
   single_event_a: assert property (
      (g.pins == $past(g.pins)) [*4] |-> (evt == '0))
      else $error("Steady pin raised a change event.");
   irq_release_a: assert property (
      (g.irq && ((q.stat & ~g.clr & ~g.mask) == '0) && (evt == '0)) |=> !g.irq)
      else $error("Interrupt not released after acknowledge.");
   masked_quiet_a: assert property (
      (!g.irq && ((evt & ~g.mask) == '0)) |=> (!g.irq || (g.mask != $past(g.mask))))
      else $error("Masked pin change raised the interrupt.");
endmodule

// ### rtl/bmpm_top.sv
// Bus-mode pin multiplexer with general purpose port and APB register file.
// Assumes straps and pins are synchronous to pclk; pads resolve the enables.
// Operation
// - Strap low selects standard PCI host bus, strap high the de-multiplexed host bus.
// - In de-multiplexed mode the write/read line tells whether a host access writes or reads.
// - In PCI mode the write/read line is never driven.
// - A high test strap puts the device in test mode; it should be low in normal use.
// - Boundary scan is held inactive while its reset is low and operable while high.
// - In PCI mode with configuration 000 the shared pins carry the 16-bit local address.
// - In PCI mode with configuration 100 the shared pins form a 16-bit general port.
// - Each port pin is set as input or output by its direction bit.
// - An output pin is driven from its port data bit.
// - Reading port data returns the pin level for each input pin.
// - Level changes on port pins are detected and reported as interrupt events.
// - A per-pin mask stops a masked pin's change from causing an interrupt.
// - The open-drain interrupt is asserted while unmasked status stands and released after.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module bmpm_top #(
   parameter int GPW = bmpm_pkg::GP_W
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [bmpm_pkg::ADDR_W-1:0] paddr,
   input  wire logic [bmpm_pkg::DATA_W-1:0] pwdata,
   output logic      [bmpm_pkg::DATA_W-1:0] prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        bus_mode_select,
   input  wire logic                        test_strap,
   input  wire logic                        scan_reset_n,
   output logic                             test_mode,
   output logic                             scan_enable,
   input  wire logic                        wr_line_i,
   output logic                             wr_line_o,
   output logic                             wr_line_oe_n,
   output logic                             bus_mode_select_write,
   input  wire logic [GPW-1:0]              general_port_pins_i,
   output logic      [GPW-1:0]              general_port_pins_o,
   output logic      [GPW-1:0]              general_port_pins_oe_n,
   input  wire logic [GPW-1:0]              local_addr_bus,
   output logic      [GPW-1:0]              bus_mode_select_addr,
   output logic                             irq,
   output logic                             irq_pin_o,
   output logic                             irq_pin_oe_n
);
   import bmpm_pkg::*;

   typedef struct packed {
      logic              mode;
      logic              test;
      logic              scan;
      logic [CFG_W-1:0]  cfg;
      logic [GPW-1:0]    dir;
      logic [GPW-1:0]    dout;
      logic [GPW-1:0]    mask;
      logic [DATA_W-1:0] rdata;
   } bmpm_top_st_t;

   bmpm_top_st_t     q;
   bmpm_top_st_t     next_q;
   logic [REG_N-1:0] sel;
   logic             acc_wr;
   logic             setup_rd;
   logic             gpio_mode;
   logic             lbi_mode;
   logic [GPW-1:0]   port_view;

   bmpm_gpio_if #(.GPW(GPW)) g ();

   // Address decode shared by the read capture and the write path.
   function automatic logic [REG_N-1:0] bmpm_decode(input logic [ADDR_W-1:0] a);
      logic [REG_N-1:0] s;
      s = '0;
      if (a == OFF_CTRL) begin
         s[SEL_CTRL] = 1'b1;
      end else if (a == OFF_DIR) begin
         s[SEL_DIR] = 1'b1;
      end else if (a == OFF_DATA) begin
         s[SEL_DATA] = 1'b1;
      end else if (a == OFF_STAT) begin
         s[SEL_STAT] = 1'b1;
      end else if (a == OFF_MASK) begin
         s[SEL_MASK] = 1'b1;
      end
      return s;
   endfunction

   assign sel       = bmpm_decode(paddr);
   assign acc_wr    = psel && penable && pwrite;
   assign setup_rd  = psel && !penable && !pwrite;
   assign gpio_mode = !q.mode && (q.cfg == CFG_GPIO);
   assign lbi_mode  = !q.mode && (q.cfg == CFG_LBI_ADDR);

   // Outputs show the data bit, inputs the synchronised pin level.
   assign port_view = (q.dout & q.dir) | (g.lvl & ~q.dir);

   always_comb begin
      next_q = q;
      next_q.mode = bus_mode_select;
      next_q.test = test_strap;
      next_q.scan = scan_reset_n;
      // Read data is captured in the setup cycle and shown in the access cycle.
      if (setup_rd) begin
         next_q.rdata = '0;
         if (sel[SEL_CTRL]) begin
            next_q.rdata[CTRL_CFG_LSB +: CFG_W] = q.cfg;
            next_q.rdata[CTRL_MODE_BIT]         = q.mode;
            next_q.rdata[CTRL_TEST_BIT]         = q.test;
            next_q.rdata[CTRL_SCAN_BIT]         = q.scan;
         end else if (sel[SEL_DIR]) begin
            next_q.rdata[GPW-1:0] = q.dir;
         end else if (sel[SEL_DATA]) begin
            next_q.rdata[GPW-1:0] = port_view;
         end else if (sel[SEL_STAT]) begin
            next_q.rdata[GPW-1:0] = g.status;
         end else if (sel[SEL_MASK]) begin
            next_q.rdata[GPW-1:0] = q.mask;
         end
      end
      if (acc_wr) begin
         if (sel[SEL_CTRL]) begin
            next_q.cfg = pwdata[CTRL_CFG_LSB +: CFG_W];
         end else if (sel[SEL_DIR]) begin
            next_q.dir = pwdata[GPW-1:0];
         end else if (sel[SEL_DATA]) begin
            next_q.dout = pwdata[GPW-1:0];
         end else if (sel[SEL_MASK]) begin
            next_q.mask = pwdata[GPW-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.mode  <= 1'b0;
         q.test  <= 1'b0;
         q.scan  <= 1'b0;
         q.cfg   <= CFG_RST;
         q.dir   <= {GPW{DIR_RST_BIT}};
         q.dout  <= {GPW{DOUT_RST_BIT}};
         q.mask  <= {GPW{MASK_RST_BIT}};
         q.rdata <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign prdata  = q.rdata;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && (sel == '0);

   assign g.en   = gpio_mode;
   assign g.mask = q.mask;
   assign g.pins = general_port_pins_i;
   assign g.clr  = (acc_wr && sel[SEL_STAT]) ? pwdata[GPW-1:0] : '0;

   bmpm_gpio_core #(.GPW(GPW)) u_core (
      .pclk    (pclk),
      .presetn (presetn),
      .g       (g)
   );

   // Shared pins: local address, general port, or host address input.
   always_comb begin
      general_port_pins_o    = '0;
      general_port_pins_oe_n = '1;
      if (lbi_mode) begin
         general_port_pins_o    = local_addr_bus;
         general_port_pins_oe_n = '0;
      end else if (gpio_mode) begin
         general_port_pins_o    = q.dout;
         general_port_pins_oe_n = ~q.dir;
      end
   end

   assign bus_mode_select_addr   = q.mode ? general_port_pins_i : '0;
   // The write/read line is only ever an input here.
   assign wr_line_o    = 1'b0;
   assign wr_line_oe_n = 1'b1;
   assign bus_mode_select_write  = q.mode && wr_line_i;

   assign test_mode    = q.test;
   assign scan_enable  = q.scan;

   assign irq          = g.irq;
   assign irq_pin_o    = 1'b0;
   assign irq_pin_oe_n = !g.irq;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence rd_setup_s;
      psel && !penable && !pwrite && (paddr == OFF_DATA);
   endsequence

   sequence rd_access_s;
      psel && penable;
   endsequence

   mode_strap_a: assert property (bus_mode_select |=> q.mode)
      else $error("Bus mode did not follow the strap.");
   bus_mode_select_dir_a: assert property (q.mode |-> (bus_mode_select_write == wr_line_i))
      else $error("Host direction not taken from write/read line.");
   pci_wr_float_a: assert property (!q.mode |-> wr_line_oe_n)
      else $error("Write/read line driven in PCI mode.");
   test_strap_a: assert property (test_strap |=> test_mode)
      else $error("Test strap did not enter test mode.");
   scan_hold_a: assert property (!scan_reset_n |=> !scan_enable)
      else $error("Boundary scan active while its reset is low.");
   addr_drive_a: assert property (
      (!q.mode && (q.cfg == CFG_LBI_ADDR)) |->
      ((general_port_pins_oe_n == '0) && (general_port_pins_o == local_addr_bus)))
      else $error("Local address not driven on shared pins.");
   gpio_drive_a: assert property (
      (!q.mode && (q.cfg == CFG_GPIO)) |->
      ((general_port_pins_oe_n == ~q.dir) && ((general_port_pins_o & q.dir) == (q.dout & q.dir))))
      else $error("Port pins not driven per direction and data.");
   dir_write_a: assert property (
      (acc_wr && (paddr == OFF_DIR)) |=> (q.dir == $past(pwdata[GPW-1:0])))
      else $error("Direction write not taken.");
   read_input_a: assert property (
      (rd_setup_s ##1 rd_access_s) |->
      ((prdata[GPW-1:0] & ~q.dir) == ($past(g.lvl) & ~q.dir)))
      else $error("Port read did not return input level.");
   irq_pin_a: assert property ((|(g.status & ~q.mask)) |-> !irq_pin_oe_n)
      else $error("Interrupt pin released with unmasked status.");
endmodule

// ### verification/bmpm_pin_model.sv
// Far side of the pin multiplexer: host write/read line and circuits on the shared pins.
// Assumes the device's enables are active low and the interrupt line has a pull-up.
`timescale 1ns/1ps
module bmpm_pin_model #(
   parameter int GPW = 16
) (
   input  wire logic           pclk,
   input  wire logic [GPW-1:0] pins_o,
   input  wire logic [GPW-1:0] pins_oe_n,
   input  wire logic [GPW-1:0] ext_val,
   input  wire logic [GPW-1:0] ext_en,
   output logic      [GPW-1:0] pins_i,
   input  wire logic           wr_o,
   input  wire logic           wr_oe_n,
   input  wire logic           bus_mode,
   input  wire logic           host_wr,
   output logic                wr_i,
   input  wire logic           irq_o,
   input  wire logic           irq_oe_n,
   output logic                irq_wire
);
   logic [GPW-1:0] spin = '0;

   // Pins that nobody drives toggle every cycle so a stale value is never read.
   always @(posedge pclk) begin
      spin <= ~spin;
   end
   assign pins_i = (~pins_oe_n & pins_o) | (pins_oe_n & ext_en & ext_val)
                 | (pins_oe_n & ~ext_en & spin);
   // The host drives the line only in de-multiplexed mode; otherwise the pull-up wins.
   assign wr_i = !wr_oe_n ? wr_o : (bus_mode ? host_wr : 1'b1);
   assign irq_wire = irq_oe_n ? 1'b1 : irq_o;
endmodule

// ### verification/bmpm_top_tb.sv
// Self-checking bench for the pin multiplexer, driving APB and the external pins.
// Assumes pready answers within a few cycles and reads data from the access edge.
`timescale 1ns/1ps
module bmpm_top_tb;
   import bmpm_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, test_mode, scan_enable, wr_o, wr_oe_n, wr_i, bus_mode_select_write;
   logic bus_mode_select = 0, test_strap = 0, scan_reset_n = 1, host_wr = 0, last_err;
   logic [15:0] gp_i, gp_o, gp_oe_n, bus_mode_select_addr, ext_val = '0, ext_en = 16'hFFFF;
   logic [15:0] local_addr_bus = '0;
   logic irq, irq_o, irq_oe_n, irq_wire;
   int failures = 0, n_checks = 0;

   bmpm_top #(.GPW(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_mode_select(bus_mode_select), .test_strap(test_strap),
      .scan_reset_n(scan_reset_n), .test_mode(test_mode), .scan_enable(scan_enable),
      .wr_line_i(wr_i), .wr_line_o(wr_o), .wr_line_oe_n(wr_oe_n),
      .bus_mode_select_write(bus_mode_select_write), .general_port_pins_i(gp_i),
      .general_port_pins_o(gp_o), .general_port_pins_oe_n(gp_oe_n),
      .local_addr_bus(local_addr_bus), .bus_mode_select_addr(bus_mode_select_addr), .irq(irq),
      .irq_pin_o(irq_o), .irq_pin_oe_n(irq_oe_n));

   bmpm_pin_model #(.GPW(16)) partner (.pclk(pclk), .pins_o(gp_o), .pins_oe_n(gp_oe_n),
      .ext_val(ext_val), .ext_en(ext_en), .pins_i(gp_i), .wr_o(wr_o),
      .wr_oe_n(wr_oe_n), .bus_mode(bus_mode_select), .host_wr(host_wr), .wr_i(wr_i),
      .irq_o(irq_o), .irq_oe_n(irq_oe_n), .irq_wire(irq_wire));

   initial begin
      forever #2 pclk = ~pclk;
   end

   task automatic end_sim;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer, entered just after a rising edge; leaves one idle cycle after it.
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         failures++;
         end_sim();
      end
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(a, 1'b1, d, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(a, 1'b0, 32'h0, r);
      chk(r, exp);
   endtask

   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (irq !== 1'b1) begin
         failures++;
         end_sim();
      end
   endtask

   initial begin
      cyc(8);
      presetn <= 1'b1;
      cyc(2);
      chk(test_mode, 1'b0);
      chk(scan_enable, 1'b1);
      chk(wr_oe_n, 1'b1);
      chk(wr_o, 1'b0);
      chk(bus_mode_select_write, 1'b0);
      chk(bus_mode_select_addr, 16'h0000);
      chk(pready, 1'b1);
      rd(OFF_CTRL, 32'h00000407);
      rd(OFF_MASK, 32'h0000FFFF);
      rd(8'h40, 32'h00000000);
      chk(last_err, 1'b1);
      ext_en <= 16'h0000;
      local_addr_bus <= 16'hA5C3;
      wr(OFF_CTRL, {29'h0, CFG_LBI_ADDR});
      cyc(1);
      chk(gp_oe_n, 16'h0000);
      chk(gp_o, 16'hA5C3);
      ext_val <= 16'hAB00;
      ext_en <= 16'hFF00;
      wr(OFF_DIR, 32'h000000FF);
      wr(OFF_DATA, 32'h00001234);
      wr(OFF_CTRL, {29'h0, CFG_GPIO});
      cyc(4);
      chk(gp_oe_n, 16'hFF00);
      chk(gp_o[7:0], 8'h34);
      rd(OFF_DATA, 32'h0000AB34);
      wr(OFF_MASK, 32'h0000FEFF);
      wr(OFF_STAT, 32'h0000FFFF);
      cyc(1);
      chk(irq, 1'b0);
      chk(irq_o, 1'b0);
      ext_val <= 16'hA900;
      cyc(6);
      chk(irq, 1'b0);
      rd(OFF_STAT, 32'h00000200);
      ext_val <= 16'hA800;
      wait_irq();
      chk(irq_wire, 1'b0);
      rd(OFF_STAT, 32'h00000300);
      wr(OFF_STAT, 32'h00000100);
      cyc(1);
      chk(irq, 1'b0);
      chk(irq_wire, 1'b1);
      rd(OFF_STAT, 32'h00000200);
      ext_en <= 16'hFFFF;
      ext_val <= 16'h5A3C;
      bus_mode_select <= 1'b1;
      host_wr <= 1'b1;
      cyc(3);
      chk(gp_oe_n, 16'hFFFF);
      chk(bus_mode_select_addr, 16'h5A3C);
      chk(bus_mode_select_write, 1'b1);
      host_wr <= 1'b0;
      cyc(2);
      chk(bus_mode_select_write, 1'b0);
      rd(OFF_CTRL, 32'h00000504);
      test_strap <= 1'b1;
      scan_reset_n <= 1'b0;
      cyc(3);
      chk(test_mode, 1'b1);
      chk(scan_enable, 1'b0);
      end_sim();
   end
endmodule
